// >>> pkg/sscfc_defs.vh
// Constants for the serial command frame checker
`ifndef SSCFC_DEFS_VH
`define SSCFC_DEFS_VH

// ============================================================
// Command opcodes
`define SSCFC_OP_NOP        8'h00
`define SSCFC_OP_STOP       8'h0a
`define SSCFC_OP_RESET      8'h0d
`define SSCFC_OP_SLEEP      8'h24
`define SSCFC_OP_MEAS_HI    4'h3

// ============================================================
// Command classes
`define SSCFC_CLS_CMD       3'h0
`define SSCFC_CLS_WRITE     3'h1
`define SSCFC_CLS_RDBYTE    3'h2
`define SSCFC_CLS_RDWORD    3'h3
`define SSCFC_CLS_UNKNOWN   3'h4

// ============================================================
// Transaction lengths in SCLK pulses
`define SSCFC_LEN_CMD       6'h10
`define SSCFC_LEN_WRITE     6'h18
`define SSCFC_LEN_RDBYTE    6'h18
`define SSCFC_LEN_RDWORD    6'h20

// ============================================================
// Pulse indices within a transaction
`define SSCFC_IDX_ADDR      6'h06
`define SSCFC_IDX_CMD       6'h07
`define SSCFC_IDX_PAR8      6'h08
`define SSCFC_IDX_DATA      6'h0f
`define SSCFC_IDX_PARW      6'h10

// ============================================================
// Status byte bit positions
`define SSCFC_ST_ECHO       3'h7
`define SSCFC_ST_ZERO       3'h6
`define SSCFC_ST_PAR        3'h5
`define SSCFC_ST_SPARE      3'h4
`define SSCFC_ST_UNK        3'h3
`define SSCFC_ST_BAD        3'h2
`define SSCFC_ST_RO         3'h1
`define SSCFC_ST_PF         3'h0

// ============================================================
// Timing
`define SSCFC_CLK_NS        20
`define SSCFC_TO_NS         100000

`endif

// >>> hw/sscfc_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sscfc_sync #(
    parameter       W    = 3,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         CLK_IN,
    input  wire         RST_IN,
    input  wire [W-1:0] D_IN,
    output reg  [W-1:0] Q_OUT
);

    reg [W-1:0] st1_reg;
    reg [W-1:0] st2_reg;
    reg [W-1:0] st3_reg;
    integer     i;

    // ============================================================
    // Stages and agreement
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            st1_reg <= INIT;
            st2_reg <= INIT;
            st3_reg <= INIT;
            Q_OUT   <= INIT;
        end else begin
            st1_reg <= D_IN;
            st2_reg <= st1_reg;
            st3_reg <= st2_reg;
            for (i = 0; i < W; i = i + 1) begin
                if (st2_reg[i] == st3_reg[i]) begin
                    Q_OUT[i] <= st3_reg[i];
                end
            end
        end
    end

endmodule // sscfc_sync

`default_nettype wire

// >>> hw/sscfc_top.v
// Serial slave command framing, echo, parity and status generation
`timescale 1ns/1ps
`default_nettype none
`include "sscfc_defs.vh"

module sscfc_top #(
    parameter TIMEOUT_CYC = `SSCFC_TO_NS / `SSCFC_CLK_NS
) (
    input  wire       CLK_IN,
    input  wire       RST_IN,
    input  wire       SELECT_LOW_IN,
    input  wire       SCLK_IN,
    input  wire       MOSI_IN,
    input  wire       PARITY_BYPASS_IN,
    input  wire       MEAS_BUSY_IN,
    input  wire       MEAS_ACTIVE_IN,
    input  wire       REG_ADDR_OK_IN,
    input  wire       REG_ADDR_RO_IN,
    input  wire [7:0] REG_RDATA_IN,
    output reg        MISO_OUT,
    output reg        MISO_OE_OUT,
    output reg  [4:0] REG_ADDR_OUT,
    output reg        WR_STB_OUT,
    output reg  [7:0] WR_DATA_OUT,
    output reg        CMD_STB_OUT,
    output reg  [7:0] CMD_CODE_OUT
);

    localparam [31:0] TO_FULL = TIMEOUT_CYC - 1;
    localparam [15:0] TO_LAST = TO_FULL[15:0];

    // ============================================================
    // Functions
    function [2:0] cmd_class;
        input [7:0] c;
        begin
            case (c[7:6])
                2'b11: cmd_class = `SSCFC_CLS_RDBYTE;
                2'b10: cmd_class = `SSCFC_CLS_RDWORD;
                2'b01: cmd_class = c[0] ? `SSCFC_CLS_UNKNOWN : `SSCFC_CLS_WRITE;
                default: begin
                    if (c == `SSCFC_OP_NOP || c == `SSCFC_OP_STOP ||
                        c == `SSCFC_OP_RESET || c == `SSCFC_OP_SLEEP ||
                        c[7:4] == `SSCFC_OP_MEAS_HI) begin
                        cmd_class = `SSCFC_CLS_CMD;
                    end else begin
                        cmd_class = `SSCFC_CLS_UNKNOWN;
                    end
                end
            endcase
        end
    endfunction

    function [5:0] class_len;
        input [2:0] cl;
        begin
            case (cl)
                `SSCFC_CLS_WRITE:  class_len = `SSCFC_LEN_WRITE;
                `SSCFC_CLS_RDBYTE: class_len = `SSCFC_LEN_RDBYTE;
                `SSCFC_CLS_RDWORD: class_len = `SSCFC_LEN_RDWORD;
                default:           class_len = `SSCFC_LEN_CMD;
            endcase
        end
    endfunction

    function is_read;
        input [2:0] cl;
        begin
            is_read = (cl == `SSCFC_CLS_RDBYTE) || (cl == `SSCFC_CLS_RDWORD);
        end
    endfunction

    // ============================================================
    // Pin synchronisation
    wire [2:0] pins_sync;
    wire       sel_low;
    wire       sclk_lvl;
    wire       mosi_lvl;

    sscfc_sync #(
        .W    (3),
        .INIT (3'h4)
    ) u_sync (
        .CLK_IN (CLK_IN),
        .RST_IN (RST_IN),
        .D_IN   ({SELECT_LOW_IN, SCLK_IN, MOSI_IN}),
        .Q_OUT  (pins_sync)
    );

    assign sel_low  = pins_sync[2];
    assign sclk_lvl = pins_sync[1];
    assign mosi_lvl = pins_sync[0];

    // ============================================================
    // State
    reg        sclk_prev_reg;
    reg        active_reg;
    reg  [5:0] bcnt_reg;
    reg  [5:0] len_reg;
    reg  [2:0] cls_reg;
    reg  [7:0] rx_reg;
    reg  [7:0] cmd_reg;
    reg  [7:0] tx_reg;
    reg        acc_reg;
    reg        unk_reg;
    reg        bad_reg;
    reg        ro_reg;
    reg        pf_reg;
    reg [15:0] to_cnt_reg;

    wire       active  = ~sel_low;
    wire       rise    = active_reg & sclk_lvl & ~sclk_prev_reg;
    wire       fall    = active_reg & ~sclk_lvl & sclk_prev_reg;
    wire [7:0] rx_new  = {rx_reg[6:0], mosi_lvl};
    wire [2:0] cls_new = cmd_class(rx_new);
    wire       blocked = (rx_new[7:4] == `SSCFC_OP_MEAS_HI && MEAS_BUSY_IN) ||
                         (rx_new == `SSCFC_OP_SLEEP && MEAS_ACTIVE_IN);
    wire       rd_cls  = is_read(cls_reg);
    wire [5:0] stat_k  = len_reg - 6'h08;
    wire [5:0] s_full  = len_reg - 6'h01 - bcnt_reg;
    wire [2:0] s_idx   = s_full[2:0];
    wire       in_data = rd_cls && bcnt_reg >= 6'h08 && bcnt_reg < stat_k;
    wire       in_stat = bcnt_reg >= 6'h08 && bcnt_reg >= stat_k;
    wire       psb     = ~(acc_reg ^ unk_reg ^ bad_reg ^ ro_reg ^ pf_reg);
    wire       timeout = bcnt_reg != 6'h00 && to_cnt_reg == TO_LAST;

    // ============================================================
    // Next MISO bit
    reg bit_out;

    always @* begin
        bit_out = ~rx_reg[0];
        if (bcnt_reg == 6'h00) begin
            bit_out = 1'b0;
        end else if (in_data) begin
            bit_out = tx_reg[7];
        end else if (in_stat) begin
            case (s_idx)
                `SSCFC_ST_ECHO:  bit_out = rd_cls ? 1'b0 : ~rx_reg[0];
                `SSCFC_ST_ZERO:  bit_out = 1'b0;
                `SSCFC_ST_PAR:   bit_out = psb;
                `SSCFC_ST_SPARE: bit_out = 1'b0;
                `SSCFC_ST_UNK:   bit_out = unk_reg;
                `SSCFC_ST_BAD:   bit_out = bad_reg;
                `SSCFC_ST_RO:    bit_out = ro_reg;
                default:         bit_out = pf_reg;
            endcase
        end
    end

    // ============================================================
    // Framing, capture and execution
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            sclk_prev_reg <= 1'b0;
            active_reg    <= 1'b0;
            bcnt_reg      <= 6'h00;
            len_reg       <= `SSCFC_LEN_CMD;
            cls_reg       <= `SSCFC_CLS_CMD;
            rx_reg        <= 8'h00;
            cmd_reg       <= 8'h00;
            tx_reg        <= 8'h00;
            acc_reg       <= 1'b0;
            unk_reg       <= 1'b0;
            bad_reg       <= 1'b0;
            ro_reg        <= 1'b0;
            pf_reg        <= 1'b0;
            to_cnt_reg    <= 16'h0000;
            MISO_OUT      <= 1'b0;
            MISO_OE_OUT   <= 1'b0;
            REG_ADDR_OUT  <= 5'h00;
            WR_STB_OUT    <= 1'b0;
            WR_DATA_OUT   <= 8'h00;
            CMD_STB_OUT   <= 1'b0;
            CMD_CODE_OUT  <= 8'h00;
        end else begin
            sclk_prev_reg <= sclk_lvl;
            active_reg    <= active;
            WR_STB_OUT    <= 1'b0;
            CMD_STB_OUT   <= 1'b0;
            if (!active) begin
                // Select released: float MISO, start over
                MISO_OE_OUT <= 1'b0;
                MISO_OUT    <= 1'b0;
                bcnt_reg    <= 6'h00;
                acc_reg     <= 1'b0;
                rx_reg      <= 8'h00;
                to_cnt_reg  <= 16'h0000;
            end else if (!active_reg) begin
                MISO_OE_OUT <= 1'b1;
                MISO_OUT    <= 1'b0;
            end else if (rise) begin
                to_cnt_reg <= 16'h0000;
                rx_reg     <= rx_new;
                bcnt_reg   <= bcnt_reg + 6'h01;
                if (bcnt_reg == `SSCFC_IDX_ADDR) begin
                    REG_ADDR_OUT <= rx_new[4:0];
                end
                if (bcnt_reg == `SSCFC_IDX_CMD) begin
                    cmd_reg <= rx_new;
                    cls_reg <= cls_new;
                    len_reg <= class_len(cls_new);
                    unk_reg <= (cls_new == `SSCFC_CLS_UNKNOWN) ||
                               (cls_new == `SSCFC_CLS_CMD && blocked);
                    bad_reg <= ((cls_new == `SSCFC_CLS_WRITE || is_read(cls_new)) &&
                                !REG_ADDR_OK_IN) ||
                               (cls_new == `SSCFC_CLS_RDWORD && rx_new[1]) ||
                               (cls_new == `SSCFC_CLS_CMD && blocked);
                    ro_reg  <= cls_new == `SSCFC_CLS_WRITE &&
                               REG_ADDR_OK_IN && REG_ADDR_RO_IN;
                    pf_reg  <= is_read(cls_new) || PARITY_BYPASS_IN;
                    if ((cls_new == `SSCFC_CLS_RDWORD && rx_new[1]) || !REG_ADDR_OK_IN) begin
                        tx_reg <= 8'h00;
                    end else begin
                        tx_reg <= REG_RDATA_IN;
                    end
                    if (cls_new == `SSCFC_CLS_RDWORD) begin
                        REG_ADDR_OUT <= REG_ADDR_OUT + 5'h01;
                    end
                    if (PARITY_BYPASS_IN && cls_new == `SSCFC_CLS_CMD && !blocked) begin
                        CMD_STB_OUT  <= 1'b1;
                        CMD_CODE_OUT <= rx_new;
                    end
                end
                if (bcnt_reg == `SSCFC_IDX_PAR8 && len_reg == `SSCFC_LEN_CMD &&
                    !PARITY_BYPASS_IN) begin
                    pf_reg <= ~^{cmd_reg, mosi_lvl};
                    if (^{cmd_reg, mosi_lvl} && !unk_reg) begin
                        CMD_STB_OUT  <= 1'b1;
                        CMD_CODE_OUT <= cmd_reg;
                    end
                end
                if (bcnt_reg == `SSCFC_IDX_DATA) begin
                    if (cls_reg == `SSCFC_CLS_WRITE) begin
                        WR_DATA_OUT <= rx_new;
                        if (PARITY_BYPASS_IN && !unk_reg && !bad_reg && !ro_reg) begin
                            WR_STB_OUT <= 1'b1;
                        end
                    end
                    if (cls_reg == `SSCFC_CLS_RDWORD) begin
                        bad_reg <= bad_reg | !REG_ADDR_OK_IN;
                        tx_reg  <= (bad_reg || !REG_ADDR_OK_IN) ? 8'h00 : REG_RDATA_IN;
                    end
                end
                if (bcnt_reg == `SSCFC_IDX_PARW && cls_reg == `SSCFC_CLS_WRITE &&
                    !PARITY_BYPASS_IN) begin
                    pf_reg <= ~^{cmd_reg, WR_DATA_OUT, mosi_lvl};
                    if (^{cmd_reg, WR_DATA_OUT, mosi_lvl} && !unk_reg && !bad_reg &&
                        !ro_reg) begin
                        WR_STB_OUT <= 1'b1;
                    end
                end
                if (bcnt_reg >= `SSCFC_IDX_PAR8 && bcnt_reg == len_reg - 6'h01) begin
                    bcnt_reg <= 6'h00;
                end
            end else if (fall) begin
                to_cnt_reg <= 16'h0000;
                MISO_OUT   <= bit_out;
                acc_reg    <= (bcnt_reg == 6'h00) ? 1'b0 : acc_reg ^ bit_out;
                if (in_data) begin
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
            end else if (timeout) begin
                bcnt_reg   <= 6'h00;
                acc_reg    <= 1'b0;
                rx_reg     <= 8'h00;
                to_cnt_reg <= 16'h0000;
            end else if (bcnt_reg != 6'h00) begin
                to_cnt_reg <= to_cnt_reg + 16'h0001;
            end
        end
    end

endmodule // sscfc_top

`default_nettype wire

// >>> sim/sscfc_master.sv
// Serial master model: select, serial clock and data towards the block
`timescale 1ns/1ps
`default_nettype none
module sscfc_master (
    input  wire logic CLK_IN,
    output var  logic SEL_N_OUT,
    output var  logic SCLK_OUT,
    output var  logic MOSI_OUT,
    input  wire logic MISO_IN
);
    initial begin
        SEL_N_OUT = 1'b1;
        SCLK_OUT  = 1'b0;
        MOSI_OUT  = 1'b1;
    end
    // =====================
    // Frame control
    task automatic open_frame();
        @(negedge CLK_IN);
        SEL_N_OUT = 1'b0;
        repeat (8) @(negedge CLK_IN);
    endtask
    task automatic close_frame();
        repeat (8) @(negedge CLK_IN);
        SEL_N_OUT = 1'b1;
        MOSI_OUT  = ~MOSI_OUT;
        repeat (8) @(negedge CLK_IN);
    endtask
    // MSB first; reply taken late in the high phase to cover sampling lag
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        for (int k = n - 1; k >= 0; k--) begin
            MOSI_OUT = tx[k];
            repeat (4) @(negedge CLK_IN);
            SCLK_OUT = 1'b1;
            repeat (4) @(negedge CLK_IN);
            rx[k] = MISO_IN;
            SCLK_OUT = 1'b0;
        end
    endtask
endmodule // sscfc_master
`default_nettype wire

// >>> sim/sscfc_top_assertions.sv
// Port-level checks for the serial command frame checker
`timescale 1ns/1ps
`default_nettype none
module sscfc_top_assertions #(
    parameter TIMEOUT_CYC = 5000
) (
    input wire logic       CLK_IN,
    input wire logic       RST_IN,
    input wire logic       SELECT_LOW_IN,
    input wire logic       SCLK_IN,
    input wire logic       MEAS_BUSY_IN,
    input wire logic       MEAS_ACTIVE_IN,
    input wire logic       REG_ADDR_OK_IN,
    input wire logic       REG_ADDR_RO_IN,
    input wire logic       MISO_OUT,
    input wire logic       MISO_OE_OUT,
    input wire logic       WR_STB_OUT,
    input wire logic       CMD_STB_OUT,
    input wire logic [7:0] CMD_CODE_OUT
);
    logic [3:0] fall_age_reg;
    logic [3:0] rise_age_reg;
    // =====================
    // Cycles since the last raw serial clock edges
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || $fell(SCLK_IN)) fall_age_reg <= 4'h0;
        else if (fall_age_reg != 4'hf) fall_age_reg <= fall_age_reg + 4'h1;
        if (RST_IN || $rose(SCLK_IN)) rise_age_reg <= 4'h0;
        else if (rise_age_reg != 4'hf) rise_age_reg <= rise_age_reg + 4'h1;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_sel_idle; SELECT_LOW_IN [*8]; endsequence
    sequence s_sel_held; !SELECT_LOW_IN [*8]; endsequence
    property p_float; s_sel_idle |-> !MISO_OE_OUT; endproperty
    a_float: assert property (p_float) else $error("miso driven while idle");
    property p_drive; s_sel_held |-> MISO_OE_OUT; endproperty
    a_drive: assert property (p_drive) else $error("miso not driven in frame");
    property p_quiet; s_sel_idle |-> !CMD_STB_OUT && !WR_STB_OUT; endproperty
    a_quiet: assert property (p_quiet) else $error("strobe outside frame");
    property p_echo_edge;
        $changed(MISO_OUT) && MISO_OE_OUT && $past(MISO_OE_OUT) |->
            fall_age_reg inside {[4'h2:4'h8]};
    endproperty
    a_echo_edge: assert property (p_echo_edge) else $error("miso moved off a fall");
    property p_cmd_rise; CMD_STB_OUT |-> rise_age_reg <= 4'h8; endproperty
    a_cmd_rise: assert property (p_cmd_rise) else $error("command run off a rise");
    property p_cmd_pulse; CMD_STB_OUT |=> !CMD_STB_OUT [*4]; endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe repeats");
    property p_wr_pulse; WR_STB_OUT |=> !WR_STB_OUT [*4]; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe repeats");
    property p_busy; CMD_STB_OUT && MEAS_BUSY_IN |-> CMD_CODE_OUT[7:4] != 4'h3; endproperty
    a_busy: assert property (p_busy) else $error("measure run while busy");
    property p_sleep; CMD_STB_OUT && MEAS_ACTIVE_IN |-> CMD_CODE_OUT != 8'h24; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep run while active");
    property p_wr_legal; WR_STB_OUT |-> REG_ADDR_OK_IN && !REG_ADDR_RO_IN; endproperty
    a_wr_legal: assert property (p_wr_legal) else $error("write to bad address");
endmodule // sscfc_top_assertions
bind sscfc_top sscfc_top_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) sscfc_top_assertions_inst (
    .CLK_IN, .RST_IN, .SELECT_LOW_IN, .SCLK_IN, .MEAS_BUSY_IN, .MEAS_ACTIVE_IN,
    .REG_ADDR_OK_IN, .REG_ADDR_RO_IN, .MISO_OUT, .MISO_OE_OUT, .WR_STB_OUT,
    .CMD_STB_OUT, .CMD_CODE_OUT);
`default_nettype wire

// >>> sim/sscfc_top_tb.sv
// Self-checking bench for the serial command frame checker
`timescale 1ns/1ps
`default_nettype none
`include "sscfc_defs.vh"
module sscfc_top_tb;
    localparam int TO_CYC = 20;
    logic       clk_in, rst_in, bypass, busy, active, sel_n, sclk, mosi;
    logic       miso, miso_oe, wr_stb, cmd_stb;
    logic [4:0] addr, wr_addr;
    logic [7:0] wr_data, cmd_code;
    int         errors = 0, checks_done = 0, cmd_cnt = 0, wr_cnt = 0;
    // Register side: 0x1f unmapped, 0x10..0x17 read-only
    wire logic       addr_ok = addr != 5'h1f;
    wire logic       addr_ro = addr[4:3] == 2'b10;
    wire logic [7:0] rdata = {addr, 3'h5};
    wire logic       miso_wire = miso_oe ? miso : 1'bz;
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    sscfc_top #(.TIMEOUT_CYC(TO_CYC)) sscfc_top_inst (
        .CLK_IN(clk_in), .RST_IN(rst_in), .SELECT_LOW_IN(sel_n), .SCLK_IN(sclk),
        .MOSI_IN(mosi), .PARITY_BYPASS_IN(bypass), .MEAS_BUSY_IN(busy),
        .MEAS_ACTIVE_IN(active), .REG_ADDR_OK_IN(addr_ok), .REG_ADDR_RO_IN(addr_ro),
        .REG_RDATA_IN(rdata), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .REG_ADDR_OUT(addr),
        .WR_STB_OUT(wr_stb), .WR_DATA_OUT(wr_data), .CMD_STB_OUT(cmd_stb),
        .CMD_CODE_OUT(cmd_code));
    sscfc_master sscfc_master_inst (.CLK_IN(clk_in), .SEL_N_OUT(sel_n), .SCLK_OUT(sclk),
        .MOSI_OUT(mosi), .MISO_IN(miso_wire));
    always @(posedge clk_in) begin
        if (cmd_stb !== 1'b0) cmd_cnt <= cmd_cnt + 1;
        if (wr_stb !== 1'b0) wr_cnt <= wr_cnt + 1;
        if (wr_stb) wr_addr <= addr;
    end
    // =====================
    // Checking helpers
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One transaction; fl = unknown, bad address, read-only, parity fail
    task automatic run(input logic [7:0] c, input logic [7:0] d, input int n,
                       input logic pflip, input logic [3:0] fl, input logic [15:0] rd,
                       input logic xc, input logic xw);
        logic [31:0] tx, rx, ex;
        int          c0, w0, lb;
        c0 = cmd_cnt;
        w0 = wr_cnt;
        if (n == 16) tx = {16'h0, c, ~^c ^ pflip, 7'h55};
        else if (!c[7]) tx = {8'h0, c, d, ~^{c, d} ^ pflip, 7'h2a};
        else tx = {c, d, d, d} >> (32 - n);
        lb = c[7] ? n - 8 : 7;
        ex = (~tx >> 1) & ((32'h1 << (n - 1)) - (32'h1 << lb));
        if (c[7]) ex = ex | ((n == 32 ? {16'h0, rd} : {24'h0, rd[7:0]}) << 8);
        ex[3:0] = fl;
        ex[5] = ~^(ex & ((32'h1 << (n - 1)) - 1));
        sscfc_master_inst.xfer(tx, n, rx);
        cmp(rx, ex, "reply bits");
        cmp(cmd_cnt - c0, xc, "command runs");
        cmp(wr_cnt - w0, xw, "write runs");
        if (xc) cmp(cmd_code, c, "command code");
        if (xw) cmp({wr_addr, wr_data}, {c[5:1], d}, "write target");
    endtask
    // =====================
    // Scenarios
    task automatic t_cmds();
        logic [7:0] ops [5] = '{`SSCFC_OP_NOP, `SSCFC_OP_STOP, `SSCFC_OP_RESET,
                                `SSCFC_OP_SLEEP, {`SSCFC_OP_MEAS_HI, 4'hc}};
        sscfc_master_inst.open_frame();
        foreach (ops[i]) run(ops[i], 8'h0, 16, 1'b0, 4'h0, 16'h0, 1'b1, 1'b0);
        run(8'h0d, 8'h0, 16, 1'b1, 4'h1, 16'h0, 1'b0, 1'b0);
        run(8'h01, 8'h0, 16, 1'b0, 4'h8, 16'h0, 1'b0, 1'b0);
        busy = 1'b1;
        active = 1'b1;
        run(8'h31, 8'h0, 16, 1'b0, 4'hc, 16'h0, 1'b0, 1'b0);
        run(8'h24, 8'h0, 16, 1'b0, 4'hc, 16'h0, 1'b0, 1'b0);
        run(`SSCFC_OP_NOP, 8'h0, 16, 1'b0, 4'h0, 16'h0, 1'b1, 1'b0);
        busy = 1'b0;
        active = 1'b0;
        sscfc_master_inst.close_frame();
        cmp(miso_oe, 1'b0, "released");
    endtask
    task automatic t_regs();
        sscfc_master_inst.open_frame();
        run(8'h46, 8'ha5, 24, 1'b0, 4'h0, 16'h0, 1'b0, 1'b1);
        run(8'h64, 8'h3c, 24, 1'b0, 4'h2, 16'h0, 1'b0, 1'b0);
        run(8'h7e, 8'h01, 24, 1'b0, 4'h4, 16'h0, 1'b0, 1'b0);
        run(8'h46, 8'h11, 24, 1'b1, 4'h1, 16'h0, 1'b0, 1'b0);
        run(8'h47, 8'h0, 16, 1'b0, 4'h8, 16'h0, 1'b0, 1'b0);
        run(8'hca, 8'h0, 24, 1'b0, 4'h1, 16'h002d, 1'b0, 1'b0);
        run(8'he5, 8'h0, 24, 1'b0, 4'h1, 16'h0095, 1'b0, 1'b0);
        run(8'hfe, 8'h0, 24, 1'b0, 4'h5, 16'h0, 1'b0, 1'b0);
        run(8'h88, 8'h0, 32, 1'b0, 4'h1, 16'h252d, 1'b0, 1'b0);
        run(8'h8a, 8'h0, 32, 1'b0, 4'h5, 16'h0, 1'b0, 1'b0);
        sscfc_master_inst.close_frame();
    endtask
    task automatic t_bypass();
        @(negedge clk_in);
        bypass = 1'b1;
        sscfc_master_inst.open_frame();
        run(8'h0d, 8'h0, 16, 1'b1, 4'h1, 16'h0, 1'b1, 1'b0);
        run(8'h46, 8'h5a, 24, 1'b1, 4'h1, 16'h0, 1'b0, 1'b1);
        sscfc_master_inst.close_frame();
        bypass = 1'b0;
    endtask
    task automatic t_gap();
        logic [31:0] rx;
        sscfc_master_inst.open_frame();
        sscfc_master_inst.xfer(32'h0d, 8, rx);
        repeat (3 * TO_CYC) @(negedge clk_in);
        run(8'h0d, 8'h0, 16, 1'b0, 4'h0, 16'h0, 1'b1, 1'b0);
        sscfc_master_inst.close_frame();
    endtask
    task automatic complete_run();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst_in = 1'b1;
        bypass = 1'b0;
        busy = 1'b0;
        active = 1'b0;
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
        t_cmds();
        t_regs();
        t_bypass();
        t_gap();
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        errors++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        complete_run();
    end
endmodule // sscfc_top_tb
`default_nettype wire
